// File: rtl/adc_scan_pkg.sv
// Package: register map, field positions and types of the scan controller
package adc_scan_pkg;
    localparam int unsigned   AXI_AW        = 4;
    localparam logic [3:0]    CSR_OFS       = 4'h0;
    localparam logic [3:0]    START_OFS     = 4'h4;
    localparam logic [1:0]    RESP_OKAY     = 2'h0;
    localparam logic [1:0]    RESP_SLVERR   = 2'h2;
    localparam logic [15:0]   CSR_RESET     = 16'h0000;
    localparam logic [15:0]   CSR_WMASK     = 16'h4bff;
    localparam logic [15:0]   START_WMASK   = 16'h2000;
    localparam int unsigned   FLAG_BIT      = 15;
    localparam int unsigned   IE_BIT        = 14;
    localparam int unsigned   GO_BIT        = 13;
    localparam int unsigned   GATE_BIT      = 11;
    localparam int unsigned   PAIR_BIT      = 9;
    localparam int unsigned   STC_BIT       = 8;
    localparam int unsigned   CKS_LSB       = 6;
    localparam int unsigned   KIND_LSB      = 4;
    localparam int unsigned   REP_BIT       = 3;
    localparam logic [1:0]    KIND_SINGLE   = 2'h0;
    localparam logic [1:0]    KIND_SCAN4    = 2'h1;
    localparam logic [1:0]    KIND_SCAN2    = 2'h2;
    localparam logic [1:0]    CKS_DIV4      = 2'h0;
    localparam int unsigned   DIV_SEL0      = 4;
    localparam int unsigned   STATES_STC0   = 50;
    localparam int unsigned   CNT_W         = 16;
    typedef struct packed {
        logic       start;
        logic [2:0] channel;
    } conv_req_s;
    typedef enum {SEQ_IDLE, SEQ_CONV} seq_state_e;
endpackage

// File: rtl/adc_scan_control.sv
// Converter scan controller with AXI4-Lite register slave
// Behaviour
// - Set end flag when every selected channel of a scan pass is converted.
// - Software clears end flag by writing 0 only after reading it as 1.
// - Transfer controller reading the result also clears the end flag.
// - Interrupt enable high makes the end request follow the end flag.
// - Trigger gate bit 11 high blocks trigger-started conversions.
// - Bit 9 controls when the flag sets in 2-channel scan mode.
// - Bit 8 selects states per conversion; default fifty.
// - Bits 7:6 pick the conversion clock; 00 is clock divided by four.
// - Bits 5:4 pick conversion mode; 01 is 4-channel scan.
// - Bit 3 high repeats the scan instead of stopping after one pass.
// - Bits 2:0 pick inputs; 011 in 4-channel scan is inputs 0 to 3.
// - Go bit 13 starts, clearing stops; single mode clears it at end.
`timescale 1ns/100ps
module adc_scan_control
    import adc_scan_pkg::*;
#(
    parameter int unsigned STATES_STC1 = 64,
    parameter int unsigned DIV_SEL1    = 8,
    parameter int unsigned DIV_SEL2    = 16,
    parameter int unsigned DIV_SEL3    = 32
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              ext_trigger,
    input  wire logic              dma_read_ack,
    output conv_req_s              conv_req,
    output logic                   conversion_busy,
    output logic                   conversion_end_request
);

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb,
                                               input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0])
            v[7:0] = data[7:0];
        if (strb[1])
            v[15:8] = data[15:8];
        lane_merge = (v & mask) | (old & ~mask);
    endfunction

    logic [15:0]      ctl_ff;
    logic             flag_ff;
    logic             armed_ff;
    logic             go_ff;
    logic             bvalid_ff;
    logic [1:0]       bresp_ff;
    logic             rvalid_ff;
    logic [1:0]       rresp_ff;
    logic [31:0]      rdata_ff;
    logic             rd_csr_ff;
    logic             trig_s1_ff;
    logic             trig_s2_ff;
    logic             trig_s3_ff;
    logic             trig_stable_ff;
    seq_state_e       state_ff;
    seq_state_e       nxt_state;
    logic [2:0]       chan_ff;
    logic [2:0]       nxt_chan;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    conv_req_s        req_ff;
    conv_req_s        nxt_req;
    logic             seq_stop;

    // Bus decode
    wire         wr_go     = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
    wire         wr_csr    = wr_go & (s_axi_awaddr == CSR_OFS);
    wire         wr_start  = wr_go & (s_axi_awaddr == START_OFS);
    wire         wr_bad    = wr_go & ~wr_csr & ~wr_start;
    wire         ar_hs     = s_axi_arvalid & ~rvalid_ff;
    wire         ar_csr    = s_axi_araddr == CSR_OFS;
    wire         ar_start  = s_axi_araddr == START_OFS;
    wire [15:0]  csr_view  = ctl_ff | (16'({flag_ff}) << FLAG_BIT);
    wire [15:0]  start_view = 16'({go_ff}) << GO_BIT;
    wire [15:0]  start_old = start_view;
    wire [15:0]  start_new = lane_merge(start_old, s_axi_wdata,
                                        s_axi_wstrb, START_WMASK);

    // Control fields
    wire         irq_en   = ctl_ff[IE_BIT];
    wire         gate     = ctl_ff[GATE_BIT];
    wire         pair_ctl = ctl_ff[PAIR_BIT];
    wire         state_count_select      = ctl_ff[STC_BIT];
    wire [1:0]   cks      = ctl_ff[CKS_LSB +: 2];
    wire [1:0]   kind     = ctl_ff[KIND_LSB +: 2];
    wire         repeat_scan = ctl_ff[REP_BIT];
    wire [2:0]   sel      = ctl_ff[2:0];

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign conv_req      = req_ff;
    assign conversion_busy = state_ff == SEQ_CONV;

    assign conversion_end_request = flag_ff & irq_en;

    wire [CNT_W-1:0] div_sel = (cks == CKS_DIV4) ? CNT_W'(DIV_SEL0) :
                               (cks == 2'h1)     ? CNT_W'(DIV_SEL1) :
                               (cks == 2'h2)     ? CNT_W'(DIV_SEL2) :
                                                   CNT_W'(DIV_SEL3);
    wire [CNT_W-1:0] states = state_count_select ? CNT_W'(STATES_STC1)
                                  : CNT_W'(STATES_STC0);
    wire [CNT_W-1:0] conv_cycles = CNT_W'(states * div_sel - CNT_W'(1));

    wire [2:0] first_ch = (kind == KIND_SCAN4) ? {sel[2], 2'b00} :
                          (kind == KIND_SCAN2) ? {sel[2:1], 1'b0} : sel;
    wire [2:0] last_ch  = sel;
    wire       conv_end = (state_ff == SEQ_CONV) & go_ff & (cnt_ff == '0);
    wire       pass_end = conv_end & (chan_ff == last_ch);
    wire       is_scan  = kind != KIND_SINGLE;

    wire flag_set = pass_end | (conv_end & (kind == KIND_SCAN2) & pair_ctl);
    // clear only after a read of 1
    wire clear_sw = wr_csr & s_axi_wstrb[1] & ~s_axi_wdata[FLAG_BIT]
                    & armed_ff;
    // trigger allowed only with gate low
    wire trig_rise  = (trig_s2_ff == trig_s3_ff) & trig_s3_ff
                      & ~trig_stable_ff;
    wire trig_start = trig_rise & ~gate;

    // Sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_chan  = chan_ff;
        nxt_cnt   = cnt_ff;
        nxt_req   = '0;
        seq_stop  = 1'b0;
        case (state_ff)
            SEQ_IDLE:
            begin
                if (go_ff)
                begin
                    nxt_state       = SEQ_CONV;
                    nxt_chan        = first_ch;
                    nxt_cnt         = conv_cycles;
                    nxt_req.start   = 1'b1;
                    nxt_req.channel = first_ch;
                end
            end
            SEQ_CONV:
            begin
                if (!go_ff)
                    nxt_state = SEQ_IDLE;
                else if (cnt_ff != '0)
                    nxt_cnt = cnt_ff - CNT_W'(1);
                else if (!pass_end)
                begin
                    nxt_chan        = chan_ff + 3'h1;
                    nxt_cnt         = conv_cycles;
                    nxt_req.start   = 1'b1;
                    nxt_req.channel = chan_ff + 3'h1;
                end
                else if (repeat_scan && is_scan)
                begin
                    nxt_chan        = first_ch;
                    nxt_cnt         = conv_cycles;
                    nxt_req.start   = 1'b1;
                    nxt_req.channel = first_ch;
                end
                else
                begin
                    nxt_state = SEQ_IDLE;
                    seq_stop  = 1'b1;
                end
            end
            default:
                nxt_state = SEQ_IDLE;
        endcase
    end

    // Sequencer and trigger registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff       <= SEQ_IDLE;
            chan_ff        <= '0;
            cnt_ff         <= '0;
            req_ff         <= '0;
            trig_s1_ff     <= 1'b0;
            trig_s2_ff     <= 1'b0;
            trig_s3_ff     <= 1'b0;
            trig_stable_ff <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            chan_ff    <= nxt_chan;
            cnt_ff     <= nxt_cnt;
            req_ff     <= nxt_req;
            trig_s1_ff <= ext_trigger;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
            // Only a level seen twice counts, filters a one-cycle glitch
            if (trig_s2_ff == trig_s3_ff)
                trig_stable_ff <= trig_s3_ff;
        end
    end

    // Registers and flag
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_ff   <= CSR_RESET;
            flag_ff  <= 1'b0;
            armed_ff <= 1'b0;
            go_ff    <= 1'b0;
        end
        else
        begin
            if (wr_csr)
                ctl_ff <= lane_merge(ctl_ff, s_axi_wdata, s_axi_wstrb,
                                     CSR_WMASK);
            // transfer read clears, set still wins
            flag_ff  <= flag_set | (flag_ff & ~clear_sw & ~dma_read_ack);
            armed_ff <= (ar_hs & ar_csr & flag_ff) | (armed_ff & ~wr_csr);
            // single mode and one-shot scan self-clear go
            if (wr_start)
                go_ff <= start_new[GO_BIT];
            else if (trig_start)
                go_ff <= 1'b1;
            else if (seq_stop)
                go_ff <= 1'b0;
        end
    end

    // AXI responses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
            rd_csr_ff <= 1'b0;
        end
        else
        begin
            if (wr_go)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
            if (ar_hs)
            begin
                rvalid_ff <= 1'b1;
                rd_csr_ff <= ar_csr;
                rresp_ff  <= (ar_csr | ar_start) ? RESP_OKAY : RESP_SLVERR;
                rdata_ff  <= ar_csr   ? {16'h0000, csr_view} :
                             ar_start ? {16'h0000, start_view} : 32'h0;
            end
            else if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_pass_end;
        pass_end && is_scan;
    endsequence
    sequence s_restart;
        ##1 conv_req.start && (conv_req.channel == $past(first_ch));
    endsequence

    property p_flag_set;
        s_pass_end |=> flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("end flag not set after scan pass");

    property p_blind_clear;
        flag_ff && !armed_ff && !dma_read_ack |=> flag_ff;
    endproperty
    a_blind_clear: assert property (p_blind_clear)
        else $error("end flag cleared without prior read");

    property p_dma_clear;
        flag_ff && dma_read_ack && !flag_set |=> !flag_ff;
    endproperty
    a_dma_clear: assert property (p_dma_clear)
        else $error("transfer read did not clear end flag");

    property p_irq;
        $rose(flag_ff) |-> conversion_end_request == irq_en;
    endproperty
    a_irq: assert property (p_irq)
        else $error("end request does not follow flag and enable");

    property p_gate;
        trig_rise && gate && !go_ff && !wr_start |=> !go_ff;
    endproperty
    a_gate: assert property (p_gate)
        else $error("gated trigger started conversion");

    property p_pair;
        conv_end && kind == KIND_SCAN2 && pair_ctl |=> flag_ff;
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair scan flag not set per channel");

    property p_states;
        conv_req.start && !state_count_select && cks == CKS_DIV4 |->
            cnt_ff == CNT_W'(STATES_STC0 * DIV_SEL0 - 1);
    endproperty
    a_states: assert property (p_states)
        else $error("conversion length wrong");

    property p_div;
        conv_req.start && cks == CKS_DIV4 |->
            cnt_ff == CNT_W'(states * CNT_W'(DIV_SEL0) - CNT_W'(1));
    endproperty
    a_div: assert property (p_div)
        else $error("divide by four not applied");

    property p_scan4;
        conv_req.start && kind == KIND_SCAN4 && sel == 3'h3 |->
            conv_req.channel <= 3'h3;
    endproperty
    a_scan4: assert property (p_scan4)
        else $error("scan4 channel outside window");

    property p_repeat;
        (s_pass_end and repeat_scan) |-> s_restart;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("continuous scan did not wrap");

    property p_sel;
        conv_req.start && kind == KIND_SINGLE |-> conv_req.channel == sel;
    endproperty
    a_sel: assert property (p_sel)
        else $error("single channel differs from select");

    property p_single_stop;
        conv_end && kind == KIND_SINGLE && !wr_start |=> !go_ff;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("go not cleared after single conversion");

    property p_reserved;
        rvalid_ff && rd_csr_ff |-> rdata_ff[13:12] == 2'h0 && !rdata_ff[10];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits read nonzero");

    property p_ascend;
        conv_end && !pass_end |=> conv_req.start &&
            conv_req.channel == $past(chan_ff) + 3'h1;
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("channel order not ascending");

endmodule

// File: verif/adc_far_side.sv
// Far-side model: converter core start log and result-reading transfer unit
`timescale 1ns/100ps
module adc_far_side
    import adc_scan_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire conv_req_s  conv_req,
    input  wire logic       conversion_end_request,
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_wait,
    output logic            dma_read_ack,
    output int              n_starts,
    output int              gap,
    output logic [23:0]     hist
);
    int         cnt_ff;
    logic [3:0] wait_ff;

    // Start spacing and channel order as the core sees them
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            n_starts <= 0;
            gap      <= 0;
            cnt_ff   <= 0;
            hist     <= 24'h000000;
        end
        else if (conv_req.start)
        begin
            n_starts <= n_starts + 1;
            gap      <= cnt_ff + 1;
            cnt_ff   <= 0;
            hist     <= {hist[20:0], conv_req.channel};
        end
        else
            cnt_ff <= cnt_ff + 1;
    end

    // result read on request
    // Delay of ack_wait cycles, so prompt and slow readers both occur
    always_ff @(posedge aclk)
    begin
        dma_read_ack <= 1'b0;
        if (!aresetn)
            wait_ff <= 4'h0;
        else if (ack_en && conversion_end_request && !dma_read_ack)
        begin
            if (wait_ff == ack_wait)
            begin
                dma_read_ack <= 1'b1;
                wait_ff      <= 4'h0;
            end
            else
                wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule

// File: verif/tb_adc_scan_control.sv
// Testbench: register-level scenarios for the converter scan controller
`timescale 1ns/100ps
module tb_adc_scan_control
    import adc_scan_pkg::*;
;
    localparam int ST1    = 4;
    localparam int DV [4] = '{DIV_SEL0, 2, 3, 5};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'h3;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        ext_trigger = 1'b0;
    logic        dma_read_ack;
    conv_req_s   conv_req;
    logic        conversion_busy;
    logic        conversion_end_request;
    logic        ack_en = 1'b0;
    logic [3:0]  ack_wait = 4'h0;
    int          n_starts;
    int          gap;
    logic [23:0] hist;
    int          n_errors = 0;
    int          cmp_count = 0;

    always #5 aclk = ~aclk;

    adc_scan_control #(
        .STATES_STC1 (ST1),
        .DIV_SEL1    (DV[1]),
        .DIV_SEL2    (DV[2]),
        .DIV_SEL3    (DV[3])
    ) adc_scan_control_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ext_trigger, .dma_read_ack,
        .conv_req, .conversion_busy, .conversion_end_request
    );

    adc_far_side adc_far_side_i (
        .aclk, .aresetn, .conv_req, .conversion_end_request, .ack_en,
        .ack_wait, .dma_read_ack, .n_starts, .gap, .hist
    );

    task automatic give_verdict();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axw(input logic [3:0] a, input logic [15:0] d,
                       input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask

    task automatic axr(input logic [3:0] a, input logic [15:0] ed,
                       input logic [1:0] er, input string nm);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, {16'h0000, ed});
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask

    task automatic wcsr(input logic [15:0] d);
        axw(CSR_OFS, d, RESP_OKAY);
    endtask

    task automatic go(input logic on);
        axw(START_OFS, on ? START_WMASK : 16'h0000, RESP_OKAY);
    endtask

    task automatic wait_starts(input int n);
        repeat (3000) if (n_starts < n) @(posedge aclk);
    endtask

    task automatic wait_idle();
        repeat (3000) if (conversion_busy !== 1'b0) @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask

    task automatic chk_seq(input int f, input int l, input int n);
        logic [23:0] h;
        int          ch;
        h = 24'h000000;
        ch = f;
        for (int i = 0; i < n; i++)
        begin
            h = {h[20:0], 3'(ch)};
            ch = (ch == l) ? f : ch + 1;
        end
        chk("channels", hist & ((24'h000001 << (3 * n)) - 24'h000001), h);
    endtask

    task automatic pulse_trig();
        @(posedge aclk);
        ext_trigger <= 1'b1;
        repeat (4) @(posedge aclk);
        ext_trigger <= 1'b0;
        repeat (10) @(posedge aclk);
    endtask

    // Whole run is under two thousand cycles; this bound only catches hangs
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        int          s;
        logic [15:0] c;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axr(CSR_OFS, CSR_RESET, RESP_OKAY, "csr rst");
        axr(START_OFS, 16'h0000, RESP_OKAY, "go rst");
        axr(4'h8, 16'h0000, RESP_SLVERR, "unmapped");
        axw(4'h8, 16'hffff, RESP_SLVERR);
        wcsr(16'hffff);
        axr(CSR_OFS, 16'h4bff, RESP_OKAY, "reserved");
        wcsr(16'h4013);
        s = n_starts;
        go(1'b1);
        wait_starts(s + 4);
        chk("gap", gap, STATES_STC0 * DIV_SEL0);
        wait_idle();
        chk_seq(0, 3, 4);
        chk("irq", 32'(conversion_end_request), 1);
        axr(START_OFS, 16'h0000, RESP_OKAY, "go off");
        wcsr(16'h0013);
        chk("irq off", 32'(conversion_end_request), 0);
        axr(CSR_OFS, 16'h8013, RESP_OKAY, "flag kept");
        wcsr(16'h4013);
        axr(CSR_OFS, 16'h4013, RESP_OKAY, "flag clr");
        ack_en <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            c = 16'h4110 | 16'(i << 6) | (i[0] ? 16'h0007 : 16'h0003);
            ack_wait <= 4'(i);
            wcsr(c);
            s = n_starts;
            go(1'b1);
            wait_starts(s + 4);
            chk("gap", gap, ST1 * DV[i]);
            wait_idle();
            chk_seq(int'(c[2]) * 4, int'(c[2:0]), 4);
            repeat (8) @(posedge aclk);
            axr(CSR_OFS, c, RESP_OKAY, "dma clr");
        end
        ack_en <= 1'b0;
        wcsr(16'h015b);
        s = n_starts;
        go(1'b1);
        wait_starts(s + 6);
        chk_seq(0, 3, 6);
        go(1'b0);
        repeat (2) @(posedge aclk);
        chk("stopped", 32'(conversion_busy), 0);
        s = n_starts;
        repeat (30) @(posedge aclk);
        chk("no start", n_starts, s);
        // Read arms the clear, so the next write empties the flag
        axr(CSR_OFS, 16'h815b, RESP_OKAY, "scan flag");
        wcsr(16'h0105);
        s = n_starts;
        go(1'b1);
        wait_starts(s + 1);
        wait_idle();
        chk_seq(5, 5, 1);
        chk("single", n_starts, s + 1);
        axr(START_OFS, 16'h0000, RESP_OKAY, "auto off");
        axr(CSR_OFS, 16'h8105, RESP_OKAY, "single flag");
        for (int p = 0; p < 2; p++)
        begin
            c = 16'h0123 | 16'(p << 9);
            wcsr(c);
            s = n_starts;
            go(1'b1);
            wait_starts(s + 2);
            repeat (2) @(posedge aclk);
            axr(CSR_OFS, c | 16'(p << 15), RESP_OKAY, "pair");
            wait_idle();
            chk_seq(2, 3, 2);
            axr(CSR_OFS, c | 16'h8000, RESP_OKAY, "scan2 end");
        end
        wcsr(16'h0905);
        s = n_starts;
        pulse_trig();
        chk("gated", n_starts, s);
        wcsr(16'h0105);
        pulse_trig();
        chk("trig", n_starts, s + 1);
        wait_idle();
        give_verdict();
    end
endmodule
